// ==== serial_port_pkg.sv ====
package serial_port_pkg;
   // register offsets on the plain register port
   localparam logic [7:0] CONFIG_ADDR = 8'hA1;
   localparam logic [7:0] MODE_ADDR = 8'hA2;
   localparam logic [7:0] STATUS_ADDR = 8'hA3;
   localparam logic [7:0] DATA_ADDR = 8'hA4;
   // config register fields
   localparam int CFG_IRQ_EN = 7;
   localparam int CFG_PORT_EN = 6;
   localparam int CFG_ROLE = 5;
   localparam int CFG_CPOL = 4;
   localparam int CFG_CPHA = 3;
   localparam int CFG_SAMPLE_EDGE = 2;
   localparam int CFG_CLK_FILT = 1;
   localparam int CFG_SEL_FILT = 0;
   localparam logic [7:0] CONFIG_RESET = 8'h20;
   // mode register fields
   localparam int MODE_THR_HI = 7;
   localparam int MODE_THR_LO = 6;
   localparam int MODE_QCLR = 5;
   localparam int MODE_RATE_LSB = 1;
   localparam int MODE_DIR = 0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // status register fields
   localparam int ST_DONE = 7;
   localparam int ST_RX_OVERRUN_FLAG = 6;
   localparam int ST_TX_OVERRUN_FLAG = 5;
   localparam int ST_TX_UNDERRUN_FLAG = 4;
   localparam int ST_RX_QUEUE_FULL = 3;
   localparam int ST_REMPTY = 2;
   localparam int ST_TX_QUEUE_FULL = 1;
   localparam int ST_TEMPTY = 0;
   // queue and byte geometry
   localparam int QUEUE_DEPTH = 4;
   localparam int BYTE_BITS = 8;
   // filter length in system clocks
   localparam int FILT_LEN = 3;
   typedef enum logic [1:0] {M_IDLE, M_LEAD, M_TRAIL} master_state_t;
endpackage

// ==== serial_port.sv ====
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
// Contract
// - separate four-byte transmit and receive queues
// - active-low select honoured only in slave role, ignored as master
// - serial clock at most a quarter of the system clock
// - clock rests high when polarity set, low when clear
// - master shift edge chosen by phase, reversed when polarity set
// - master samples on rising edge if sample bit set, else falling
// - slave samples rising, shifts falling when polarity equals phase; else reversed
// - two bits enable filters on select, and on clock plus data in
// - role bit set means master, clear means slave
// - two-bit threshold raises interrupt after 1 to 4 bytes
// - queue clear bit empties both queues
// - master rate field selects divisors 4,6,8,16,32,64,128,256
// - direction bit one msb first, zero lsb first
// - done flag set when the byte count reaches the threshold, cleared by write zero or disable
// - receive into full queue sets rx overrun flag and interrupt; here a data read in the same cycle drops the byte unflagged
// - write to full transmit queue sets tx overrun flag and interrupt
// - transfer with empty transmit queue sets underrun flag and interrupt
// - four read-only queue full and empty status bits
// - data read pops receive queue, data write pushes transmit queue
// - enable bit turns port on; interrupt enable gates flags
module serial_port
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   output logic sclk_o,
   output logic sclk_oe_o,
   input wire logic sclk_i,
   output logic data_out_o,
   input wire logic serial_data_in_i,
   input wire logic slave_select_n_i
);
   localparam int PW = $clog2(serial_port_pkg::QUEUE_DEPTH);

   // divisor half period for rate codes 000 to 110, in system clocks
   function automatic logic [6:0] half_div(input logic [2:0] code);
      case (code)
         3'h0: half_div = 7'h02;
         3'h1: half_div = 7'h03;
         3'h2: half_div = 7'h04;
         3'h3: half_div = 7'h08;
         3'h4: half_div = 7'h10;
         3'h5: half_div = 7'h20;
         3'h6: half_div = 7'h40;
         default: half_div = 7'h40;
      endcase
   endfunction
   // rate 111 needs 128 which overflows 7 bits, so widen via the 8-bit form
   function automatic logic [7:0] half_cnt(input logic [2:0] code);
      half_cnt = (code == 3'h7) ? 8'h80 : {1'b0, half_div(code)};
   endfunction

   // input synchronisers: two flops before anything reads the pins
   logic [1:0] sck_s_q, din_s_q, sel_s_q;
   logic [1:0] sck_s_d, din_s_d, sel_s_d;
   // filter stage: value accepted once stable for FILT_LEN clocks
   logic sck_f_q, din_f_q, sel_f_q, sck_f_d, din_f_d, sel_f_d;
   logic [1:0] sck_c_q, din_c_q, sel_c_q, sck_c_d, din_c_d, sel_c_d;
   logic sck_prev_q, sck_prev_d;
   logic sck_v, din_v, sel_v;

   // registers
   logic [7:0] cfg_q, cfg_d, mode_q, mode_d;
   logic done_q, rx_overrun_flag_q, tx_overrun_flag_q, tx_underrun_flag_q, done_d, rx_overrun_flag_d, tx_overrun_flag_d, tx_underrun_flag_d;
   logic [7:0] rdata_q, rdata_d;
   logic irq_q, irq_d;

   // queues
   logic [7:0] txq_q [serial_port_pkg::QUEUE_DEPTH];
   logic [7:0] rxq_q [serial_port_pkg::QUEUE_DEPTH];
   logic [PW-1:0] tx_rp_q, tx_wp_q, rx_rp_q, rx_wp_q;
   logic [PW-1:0] tx_rp_d, tx_wp_d, rx_rp_d, rx_wp_d;
   logic [PW:0] tx_n_q, rx_n_q, tx_n_d, rx_n_d;

   // shifter
   serial_port_pkg::master_state_t mst_q, mst_d;
   logic [7:0] div_q, div_d;
   logic [7:0] sh_tx_q, sh_tx_d, sh_rx_q, sh_rx_d;
   logic [3:0] bit_q, bit_d;
   logic [2:0] xfer_cnt_q, xfer_cnt_d;
   logic sclk_q, sclk_d, dout_q, dout_d, oe_q, oe_d;

   logic en, master, cpol, cpha, msb_first;
   logic wr_data, rd_data, q_clear;
   logic push_rx, pop_tx, byte_done;
   logic lead_edge, trail_edge, do_sample, do_shift, s_rise, s_fall;
   logic samp_dly_q, samp_dly_d;
   logic [7:0] rx_byte;
   logic [2:0] thr;

   assign en = cfg_q[serial_port_pkg::CFG_PORT_EN];
   assign master = cfg_q[serial_port_pkg::CFG_ROLE];
   assign cpol = cfg_q[serial_port_pkg::CFG_CPOL];
   assign cpha = cfg_q[serial_port_pkg::CFG_CPHA];
   assign msb_first = mode_q[serial_port_pkg::MODE_DIR];
   assign wr_data = wr_i && addr_i == serial_port_pkg::DATA_ADDR;
   assign rd_data = rd_i && addr_i == serial_port_pkg::DATA_ADDR;
   assign q_clear = wr_i && addr_i == serial_port_pkg::MODE_ADDR
      && wdata_i[serial_port_pkg::MODE_QCLR];
   assign thr = {1'b0, mode_q[serial_port_pkg::MODE_THR_HI:serial_port_pkg::MODE_THR_LO]};

   // synchronise and optionally filter the slave-side pins
   always_comb
   begin
      sck_s_d = {sck_s_q[0], sclk_i};
      din_s_d = {din_s_q[0], serial_data_in_i};
      sel_s_d = {sel_s_q[0], slave_select_n_i};
      sck_c_d = (sck_s_q[1] == sck_f_q) ? 2'h0 : sck_c_q + 2'h1;
      din_c_d = (din_s_q[1] == din_f_q) ? 2'h0 : din_c_q + 2'h1;
      sel_c_d = (sel_s_q[1] == sel_f_q) ? 2'h0 : sel_c_q + 2'h1;
      sck_f_d = (sck_c_q == 2'(serial_port_pkg::FILT_LEN - 1)) ? sck_s_q[1] : sck_f_q;
      din_f_d = (din_c_q == 2'(serial_port_pkg::FILT_LEN - 1)) ? din_s_q[1] : din_f_q;
      sel_f_d = (sel_c_q == 2'(serial_port_pkg::FILT_LEN - 1)) ? sel_s_q[1] : sel_f_q;
      if (sck_s_q[1] == sck_f_q)
         sck_c_d = 2'h0;
      sck_prev_d = sck_v;
   end
   // filtered or raw view chosen per enable bit
   assign sck_v = cfg_q[serial_port_pkg::CFG_CLK_FILT] ? sck_f_q : sck_s_q[1];
   assign din_v = cfg_q[serial_port_pkg::CFG_CLK_FILT] ? din_f_q : din_s_q[1];
   assign sel_v = cfg_q[serial_port_pkg::CFG_SEL_FILT] ? sel_f_q : sel_s_q[1];
   assign s_rise = sck_v && !sck_prev_q;
   assign s_fall = !sck_v && sck_prev_q;

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         sck_s_q <= 2'h0;
         din_s_q <= 2'h0;
         sel_s_q <= 2'h3;
         sck_c_q <= 2'h0;
         din_c_q <= 2'h0;
         sel_c_q <= 2'h0;
         sck_f_q <= 1'b0;
         din_f_q <= 1'b0;
         sel_f_q <= 1'b1;
         sck_prev_q <= 1'b0;
         samp_dly_q <= 1'b0;
      end
      else
      begin
         sck_s_q <= sck_s_d;
         din_s_q <= din_s_d;
         sel_s_q <= sel_s_d;
         sck_c_q <= sck_c_d;
         din_c_q <= din_c_d;
         sel_c_q <= sel_c_d;
         sck_f_q <= sck_f_d;
         din_f_q <= din_f_d;
         sel_f_q <= sel_f_d;
         sck_prev_q <= sck_prev_d;
         samp_dly_q <= samp_dly_d;
      end
   end

   // edge roles: lead is the first edge away from idle level
   always_comb
   begin
      lead_edge = 1'b0;
      trail_edge = 1'b0;
      do_sample = 1'b0;
      do_shift = 1'b0;
      samp_dly_d = 1'b0;
      if (master)
      begin
         // divider reached half period: toggle clock
         if (mst_q != serial_port_pkg::M_IDLE && div_q == 8'h01)
         begin
            lead_edge = (mst_q == serial_port_pkg::M_LEAD);
            trail_edge = (mst_q == serial_port_pkg::M_TRAIL);
         end
         // new clock level after the edge decides rise or fall
         do_shift = (lead_edge || trail_edge)
            && ((lead_edge ^ cpol) == (cpha ^ cpol));
         // the slave's new bit reaches the synchroniser late, so take it one cycle after the edge
         samp_dly_d = (lead_edge || trail_edge)
            && ((lead_edge ^ cpol) == cfg_q[serial_port_pkg::CFG_SAMPLE_EDGE]);
         do_sample = samp_dly_q;
      end
      else if (!sel_v)
      begin
         do_sample = (cpol == cpha) ? s_rise : s_fall;
         do_shift = (cpol == cpha) ? s_fall : s_rise;
      end
   end
   // bit order on the assembled receive byte
   assign rx_byte = msb_first ? {sh_rx_q[6:0], din_v} : {din_v, sh_rx_q[7:1]};
   assign byte_done = do_sample && bit_q == 4'(serial_port_pkg::BYTE_BITS - 1);
   assign push_rx = byte_done && en;
   assign pop_tx = en && bit_q == 4'h0 && tx_n_q != '0
      && (master ? mst_q == serial_port_pkg::M_IDLE : do_shift == 1'b0 && bit_q == 4'h0);

   // shifter and master clock generator
   always_comb
   begin
      mst_d = mst_q;
      div_d = div_q;
      sh_tx_d = sh_tx_q;
      sh_rx_d = sh_rx_q;
      bit_d = bit_q;
      sclk_d = cpol;
      dout_d = dout_q;
      oe_d = master && en;
      if (!en || q_clear)
      begin
         mst_d = serial_port_pkg::M_IDLE;
         bit_d = 4'h0;
      end
      else if (master)
      begin
         case (mst_q)
            serial_port_pkg::M_IDLE:
            begin
               if (tx_n_q != '0)
               begin
                  mst_d = serial_port_pkg::M_LEAD;
                  div_d = half_cnt(mode_q[3:serial_port_pkg::MODE_RATE_LSB]);
                  sh_tx_d = txq_q[tx_rp_q];
                  dout_d = msb_first ? txq_q[tx_rp_q][7] : txq_q[tx_rp_q][0];
                  bit_d = 4'h0;
               end
            end
            serial_port_pkg::M_LEAD:
            begin
               sclk_d = cpol;
               div_d = div_q - 8'h01;
               if (div_q == 8'h01)
               begin
                  mst_d = serial_port_pkg::M_TRAIL;
                  sclk_d = !cpol;
                  div_d = half_cnt(mode_q[3:serial_port_pkg::MODE_RATE_LSB]);
               end
            end
            serial_port_pkg::M_TRAIL:
            begin
               sclk_d = !cpol;
               div_d = div_q - 8'h01;
               if (div_q == 8'h01)
               begin
                  sclk_d = cpol;
                  div_d = half_cnt(mode_q[3:serial_port_pkg::MODE_RATE_LSB]);
                  mst_d = (bit_q == 4'(serial_port_pkg::BYTE_BITS))
                     ? serial_port_pkg::M_IDLE : serial_port_pkg::M_LEAD;
               end
            end
            default: mst_d = serial_port_pkg::M_IDLE;
         endcase
         if (lead_edge || trail_edge)
            sclk_d = lead_edge ? !cpol : cpol;
      end
      else if (pop_tx)
      begin
         sh_tx_d = txq_q[tx_rp_q];
         dout_d = msb_first ? txq_q[tx_rp_q][7] : txq_q[tx_rp_q][0];
      end
      if (en && do_sample)
      begin
         sh_rx_d = rx_byte;
         bit_d = byte_done ? (master ? 4'(serial_port_pkg::BYTE_BITS) : 4'h0) : bit_q + 4'h1;
      end
      if (en && do_shift && bit_q != 4'h0)
      begin
         sh_tx_d = msb_first ? {sh_tx_q[6:0], 1'b0} : {1'b0, sh_tx_q[7:1]};
         dout_d = msb_first ? sh_tx_q[6] : sh_tx_q[1];
      end
      if (master && mst_q == serial_port_pkg::M_TRAIL && div_q == 8'h01
         && bit_q == 4'(serial_port_pkg::BYTE_BITS))
         bit_d = 4'h0;
   end

   // queues: counts and pointers, with full and empty guards; overrun and underrun flags are set with the registers
   always_comb
   begin
      tx_rp_d = tx_rp_q;
      tx_wp_d = tx_wp_q;
      rx_rp_d = rx_rp_q;
      rx_wp_d = rx_wp_q;
      tx_n_d = tx_n_q;
      rx_n_d = rx_n_q;
      if (pop_tx && master)
      begin
         tx_rp_d = tx_rp_q + 1'b1;
         tx_n_d = tx_n_d - 1'b1;
      end
      else if (!master && en && !sel_v && do_shift && bit_q == 4'h0 && tx_n_q != '0)
      begin
         tx_rp_d = tx_rp_q + 1'b1;
         tx_n_d = tx_n_d - 1'b1;
      end
      if (wr_data && tx_n_q != (PW+1)'(serial_port_pkg::QUEUE_DEPTH))
      begin
         tx_wp_d = tx_wp_q + 1'b1;
         tx_n_d = tx_n_d + 1'b1;
      end
      if (push_rx && rx_n_q != (PW+1)'(serial_port_pkg::QUEUE_DEPTH))
      begin
         rx_wp_d = rx_wp_q + 1'b1;
         rx_n_d = rx_n_d + 1'b1;
      end
      if (rd_data && rx_n_q != '0)
      begin
         rx_rp_d = rx_rp_q + 1'b1;
         rx_n_d = rx_n_d - 1'b1;
      end
      if (q_clear)
      begin
         tx_rp_d = '0;
         tx_wp_d = '0;
         rx_rp_d = '0;
         rx_wp_d = '0;
         tx_n_d = '0;
         rx_n_d = '0;
      end
   end

   // register writes and flags; hardware set beats software clear
   always_comb
   begin
      cfg_d = cfg_q;
      mode_d = mode_q;
      done_d = done_q;
      rx_overrun_flag_d = rx_overrun_flag_q;
      tx_overrun_flag_d = tx_overrun_flag_q;
      tx_underrun_flag_d = tx_underrun_flag_q;
      xfer_cnt_d = xfer_cnt_q;
      rdata_d = 8'h00;
      if (wr_i && addr_i == serial_port_pkg::CONFIG_ADDR)
         cfg_d = wdata_i;
      if (wr_i && addr_i == serial_port_pkg::MODE_ADDR)
         mode_d = wdata_i & ~(8'h01 << serial_port_pkg::MODE_QCLR); // clear is a strobe
      if (wr_i && addr_i == serial_port_pkg::STATUS_ADDR)
      begin
         done_d = done_q & wdata_i[serial_port_pkg::ST_DONE];
         rx_overrun_flag_d = rx_overrun_flag_q & wdata_i[serial_port_pkg::ST_RX_OVERRUN_FLAG];
         tx_overrun_flag_d = tx_overrun_flag_q & wdata_i[serial_port_pkg::ST_TX_OVERRUN_FLAG];
         tx_underrun_flag_d = tx_underrun_flag_q & wdata_i[serial_port_pkg::ST_TX_UNDERRUN_FLAG];
      end
      if (byte_done && en)
      begin
         xfer_cnt_d = (xfer_cnt_q >= thr) ? 3'h0 : xfer_cnt_q + 3'h1;
         if (xfer_cnt_q >= thr)
            done_d = 1'b1;
         if (rx_n_q == (PW+1)'(serial_port_pkg::QUEUE_DEPTH) && !rd_data)
            rx_overrun_flag_d = 1'b1;
      end
      if (wr_data && tx_n_q == (PW+1)'(serial_port_pkg::QUEUE_DEPTH))
         tx_overrun_flag_d = 1'b1;
      if (en && !master && !sel_v && do_shift && bit_q == 4'h0 && tx_n_q == '0)
         tx_underrun_flag_d = 1'b1;
      if (!en)
      begin
         done_d = 1'b0;
         rx_overrun_flag_d = 1'b0;
         tx_overrun_flag_d = 1'b0;
         tx_underrun_flag_d = 1'b0;
         xfer_cnt_d = 3'h0;
      end
      if (rd_i)
      begin
         case (addr_i)
            serial_port_pkg::CONFIG_ADDR: rdata_d = cfg_q;
            serial_port_pkg::MODE_ADDR: rdata_d = mode_q;
            serial_port_pkg::STATUS_ADDR:
               rdata_d = {done_q, rx_overrun_flag_q, tx_overrun_flag_q, tx_underrun_flag_q,
                  rx_n_q == (PW+1)'(serial_port_pkg::QUEUE_DEPTH), rx_n_q == '0,
                  tx_n_q == (PW+1)'(serial_port_pkg::QUEUE_DEPTH), tx_n_q == '0};
            serial_port_pkg::DATA_ADDR: rdata_d = rxq_q[rx_rp_q];
            default: rdata_d = 8'h00;
         endcase
      end
      irq_d = cfg_q[serial_port_pkg::CFG_IRQ_EN]
         && (done_q || rx_overrun_flag_q || tx_overrun_flag_q || tx_underrun_flag_q);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         cfg_q <= serial_port_pkg::CONFIG_RESET;
         mode_q <= serial_port_pkg::MODE_RESET;
         {done_q, rx_overrun_flag_q, tx_overrun_flag_q, tx_underrun_flag_q} <= 4'h0;
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
         xfer_cnt_q <= 3'h0;
         tx_rp_q <= '0;
         tx_wp_q <= '0;
         rx_rp_q <= '0;
         rx_wp_q <= '0;
         tx_n_q <= '0;
         rx_n_q <= '0;
         mst_q <= serial_port_pkg::M_IDLE;
         div_q <= 8'h00;
         sh_tx_q <= 8'h00;
         sh_rx_q <= 8'h00;
         bit_q <= 4'h0;
         sclk_q <= 1'b0;
         dout_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;
         mode_q <= mode_d;
         {done_q, rx_overrun_flag_q, tx_overrun_flag_q, tx_underrun_flag_q} <= {done_d, rx_overrun_flag_d, tx_overrun_flag_d, tx_underrun_flag_d};
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         xfer_cnt_q <= xfer_cnt_d;
         tx_rp_q <= tx_rp_d;
         tx_wp_q <= tx_wp_d;
         rx_rp_q <= rx_rp_d;
         rx_wp_q <= rx_wp_d;
         tx_n_q <= tx_n_d;
         rx_n_q <= rx_n_d;
         mst_q <= mst_d;
         div_q <= div_d;
         sh_tx_q <= sh_tx_d;
         sh_rx_q <= sh_rx_d;
         bit_q <= bit_d;
         sclk_q <= sclk_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
      end
   end

   // queue storage, no reset needed on data words
   always_ff @(posedge clk_i)
   begin
      if (wr_data && tx_n_q != (PW+1)'(serial_port_pkg::QUEUE_DEPTH))
         txq_q[tx_wp_q] <= wdata_i;
      if (push_rx && rx_n_q != (PW+1)'(serial_port_pkg::QUEUE_DEPTH))
         rxq_q[rx_wp_q] <= rx_byte;
   end

   assign rdata_o = rdata_q;
   assign irq_o = irq_q;
   assign sclk_o = sclk_q;
   assign sclk_oe_o = oe_q;
   assign data_out_o = dout_q;

   // checks
   sequence clear_write_s;
      wr_i && addr_i == serial_port_pkg::MODE_ADDR && wdata_i[serial_port_pkg::MODE_QCLR];
   endsequence
   queue_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clear_write_s |=> tx_n_q == '0 && rx_n_q == '0)
      else $error("queue clear did not empty queues");
   idle_level_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mst_q == serial_port_pkg::M_IDLE && $past(mst_q) == serial_port_pkg::M_IDLE
      && $stable(cpol) |-> sclk_q == cpol)
      else $error("serial clock not at idle level");
   queue_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      tx_n_q <= (PW+1)'(serial_port_pkg::QUEUE_DEPTH)
      && rx_n_q <= (PW+1)'(serial_port_pkg::QUEUE_DEPTH))
      else $error("queue count above depth");
   tx_overrun_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      en && wr_data && tx_n_q == (PW+1)'(serial_port_pkg::QUEUE_DEPTH) |=> tx_overrun_flag_q)
      else $error("tx overrun not flagged");
   disable_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !en |=> !done_q && !rx_overrun_flag_q && !tx_overrun_flag_q && !tx_underrun_flag_q)
      else $error("flags survive disable");
   irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !cfg_q[serial_port_pkg::CFG_IRQ_EN] |=> !irq_o)
      else $error("interrupt not gated");
   master_start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      en && master && mst_q == serial_port_pkg::M_IDLE && tx_n_q != '0
      && !q_clear && !$rose(en) |=> mst_q == serial_port_pkg::M_LEAD)
      else $error("master did not start");
   read_data_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_data && rx_n_q != '0 |=> rdata_o == $past(rxq_q[rx_rp_q]))
      else $error("data read wrong byte");
endmodule

// ==== serial_partner.sv ====
`timescale 1ns/100ps
// far-side device acting as a slave with polarity and phase both clear
// the port has no select output, so frames are framed by counting edges
module serial_partner
(
   input wire logic sclk_i,
   input wire logic data_i,
   input wire logic [7:0] tx_byte_i,
   input wire logic msb_first_i,
   output logic data_o,
   output logic [7:0] rx_byte_o
);
   logic [7:0] sh_q = 8'h00;
   logic [7:0] rx_sh = 8'h00;
   int bit_q = 0;
   // sample on the rising edge, as polarity equals phase
   always @(posedge sclk_i)
   begin
      rx_sh = msb_first_i ? {rx_sh[6:0], data_i} : {data_i, rx_sh[7:1]};
      bit_q++;
      if (bit_q == 8)
      begin
         rx_byte_o = rx_sh;
         bit_q = 0;
      end
   end
   // shift on the falling edge; the next byte's first bit waits between frames
   always @(negedge sclk_i)
   begin
      if (bit_q == 1)
         sh_q = msb_first_i ? tx_byte_i << 1 : tx_byte_i >> 1;
      else if (bit_q != 0)
         sh_q = msb_first_i ? sh_q << 1 : sh_q >> 1;
   end
   // only edges from the port move data, so rates up to a quarter clock are met
   assign data_o = (bit_q == 0) ? (msb_first_i ? tx_byte_i[7] : tx_byte_i[0])
                                : (msb_first_i ? sh_q[7] : sh_q[0]);
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic irq_o, sclk_o, sclk_oe_o, data_out_o, serial_data_in;
   logic slave_select_n_i = 1'b1; // inactive: the master role must not care anyway
   logic [7:0] part_tx = 8'h3C;
   logic part_msb = 1'b1;
   logic [7:0] part_rx, v, b;
   logic sclk_q = 1'b0;
   logic ext_sclk = 1'b0;
   int err_count = 0;
   int n_tests = 0;
   int cnt = 0;
   int per = 0;
   int n_rise = 0;
   int div [8] = '{4, 6, 8, 16, 32, 64, 128, 256};
   always #4 clk_i = ~clk_i;
   serial_port u_serial_port (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
      .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sclk_i(ext_sclk), .data_out_o(data_out_o),
      .serial_data_in_i(serial_data_in), .slave_select_n_i(slave_select_n_i));
   serial_partner u_serial_partner (.sclk_i(sclk_o), .data_i(data_out_o),
      .tx_byte_i(part_tx), .msb_first_i(part_msb), .data_o(serial_data_in), .rx_byte_o(part_rx));
   // serial clock period in system clocks, measured rise to rise
   always @(posedge clk_i)
   begin
      sclk_q <= sclk_o;
      if (sclk_o === 1'b1 && sclk_q === 1'b0)
      begin
         per <= cnt + 1;
         cnt <= 0;
         n_rise <= n_rise + 1;
      end
      else
         cnt <= cnt + 1;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // wait for the first clock edge, then for 300 quiet cycles (longer than any period)
   task automatic xfer_wait;
      int r0;
      int k;
      r0 = n_rise;
      for (k = 0; k < 3000 && n_rise == r0; k++) @(posedge clk_i);
      for (k = 0; k < 30000 && cnt < 300; k++) @(posedge clk_i);
   endtask
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #800_000;
      err_count++;
      complete_run;
   end
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(serial_port_pkg::CONFIG_ADDR, v); `CHK(v, 8'h20)
      rd(serial_port_pkg::MODE_ADDR, v); `CHK(v, 8'h00)
      wr(serial_port_pkg::STATUS_ADDR, 8'h0F);
      rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v, 8'h05)
      rd(8'h00, v); `CHK(v, 8'h00)
      // master, enabled, irq on, sample rising, polarity and phase clear
      wr(serial_port_pkg::CONFIG_ADDR, 8'hE4);
      `CHK(sclk_o, 1'b0)
      for (int r = 0; r < 8; r++)
      begin
         b = 8'hA0 + 8'(r);
         part_tx <= 8'h3C ^ 8'(r);
         wr(serial_port_pkg::MODE_ADDR, {4'h0, 3'(r), 1'b1});
         wr(serial_port_pkg::DATA_ADDR, b);
         xfer_wait;
         `CHK(per, div[r])
         `CHK(sclk_o, 1'b0)
         `CHK(sclk_oe_o, 1'b1)
         `CHK(part_rx, b)
         rd(serial_port_pkg::DATA_ADDR, v); `CHK(v, 8'h3C ^ 8'(r))
         rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v, 8'h85)
         `CHK(irq_o, 1'b1)
         wr(serial_port_pkg::STATUS_ADDR, 8'h00);
         rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v[7], 1'b0)
         `CHK(irq_o, 1'b0)
      end
      // least significant bit first
      part_msb <= 1'b0;
      part_tx <= 8'h6D;
      wr(serial_port_pkg::MODE_ADDR, 8'h00);
      wr(serial_port_pkg::DATA_ADDR, 8'h1E);
      xfer_wait;
      `CHK(part_rx, 8'h1E)
      rd(serial_port_pkg::DATA_ADDR, v); `CHK(v, 8'h6D)
      part_msb <= 1'b1;
      // slowest rate: six writes while one byte is in flight overflow the queue
      wr(serial_port_pkg::MODE_ADDR, 8'h0F);
      for (int k = 0; k < 6; k++) wr(serial_port_pkg::DATA_ADDR, 8'(k));
      rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v, 8'hA6)
      `CHK(irq_o, 1'b1)
      wr(serial_port_pkg::MODE_ADDR, 8'h2F);
      rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v[1:0], 2'b01)
      rd(serial_port_pkg::MODE_ADDR, v); `CHK(v, 8'h0F)
      xfer_wait;
      // threshold of four bytes, then a fifth byte into a full receive queue
      wr(serial_port_pkg::MODE_ADDR, 8'hE1);
      wr(serial_port_pkg::STATUS_ADDR, 8'h00);
      for (int k = 0; k < 3; k++) wr(serial_port_pkg::DATA_ADDR, 8'(k));
      xfer_wait;
      rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v[7], 1'b0)
      wr(serial_port_pkg::DATA_ADDR, 8'h33);
      xfer_wait;
      rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v, 8'h89)
      wr(serial_port_pkg::DATA_ADDR, 8'h44);
      xfer_wait;
      rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v[6], 1'b1)
      wr(serial_port_pkg::CONFIG_ADDR, 8'hF4);
      repeat (2) @(posedge clk_i);
      `CHK(sclk_o, 1'b1)
      wr(serial_port_pkg::CONFIG_ADDR, 8'hB4);
      rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v[7:4], 4'h0)
      // slave role, select low, empty transmit queue: the eighth shift underruns
      slave_select_n_i <= 1'b0;
      wr(serial_port_pkg::CONFIG_ADDR, 8'hC0);
      repeat (4) @(posedge clk_i);
      `CHK(sclk_oe_o, 1'b0)
      for (int k = 0; k < 16; k++)
      begin
         ext_sclk <= !ext_sclk;
         repeat (4) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
      rd(serial_port_pkg::STATUS_ADDR, v); `CHK(v[4], 1'b1)
      complete_run;
   end
endmodule
